// ===== verilog/acr_regs.vh
// register offsets, field positions, reset values and timing counts for the converter control bank
// Function
// - selector codes 0-11 route analog inputs
// - selector codes 12-29 connect no input
// - code 30 dac, code 31 reference buffer
// - writing start flag one begins conversion
// - start flag holds one until completion
// - enable bit powers converter, else idle
// - unimplemented control bits read zero
// - right justify zeroes high six bits
// - left justify zeroes low six bits
// - clock selector divides system clock
// - selector x11 uses dedicated rc clock
// - negative reference ground or external pin
// - positive reference supply, pin, fixed, reserved
// - left justify puts bits 9-2 high
// - control registers clear on every reset
// - completion sets done flag, loads result
// - early clear stores partial, fills last bit
// - low byte placement for both justifications
// - compare trigger sets start flag
`ifndef ACR_REGS_VH
`define ACR_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ACR_OFF_CTRL0 12'h000
`define ACR_OFF_CTRL1 12'h004
`define ACR_OFF_RESH 12'h008
`define ACR_OFF_RESL 12'h00c
`define ACR_OFF_STAT 12'h010

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACR_C0_EN 0
`define ACR_C0_GO 1
`define ACR_C0_SEL_LO 2
`define ACR_C0_SEL_HI 6
`define ACR_C1_PREF_LO 0
`define ACR_C1_PREF_HI 1
`define ACR_C1_NREF 2
`define ACR_C1_CLK_LO 4
`define ACR_C1_CLK_HI 6
`define ACR_C1_JUST 7
`define ACR_ST_DONE 0

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define ACR_CTRL0_RST 8'h00
`define ACR_CTRL1_RST 8'h00
`define ACR_SEL_LAST_AN 5'h0b
`define ACR_SEL_DAC 5'h1e
`define ACR_SEL_REFBUF 5'h1f
`define ACR_SEL_NONE 5'h1d

// ----------------------------------------
// timing
// ----------------------------------------
`define ACR_RES_BITS 10
`define ACR_TAD_PER_CONV 11

`endif

// ===== verilog/acr_clkdiv.v
// conversion clock enable generator
`timescale 1ns/100ps
`default_nettype none
`include "acr_regs.vh"

module acr_clkdiv (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // control
  input wire run,
  input wire [2:0] clock_select,
  input wire rc_tick,
  // tick out
  output reg tad_tick
);

  reg [5:0] count;
  reg [5:0] limit;

  // ----------------------------------------
  // divide table
  // ----------------------------------------
  // divide ratio decode
  always @* begin
    case (clock_select)
      3'h0: limit = 6'h01;
      3'h4: limit = 6'h03;
      3'h1: limit = 6'h07;
      3'h5: limit = 6'h0f;
      3'h2: limit = 6'h1f;
      3'h6: limit = 6'h3f;
      default: limit = 6'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b || !run) begin
      count <= 6'h00;
      tad_tick <= 1'b0;
    end else if (clock_select[1:0] == 2'b11) begin
      count <= 6'h00;
      tad_tick <= rc_tick;
    end else if (count == limit) begin
      count <= 6'h00;
      tad_tick <= 1'b1;
    end else begin
      count <= count + 6'h01;
      tad_tick <= 1'b0;
    end
  end

endmodule // acr_clkdiv
`default_nettype wire

// ===== verilog/acr_sar.v
// successive approximation sequencer driving the analog comparator
`timescale 1ns/100ps
`default_nettype none
`include "acr_regs.vh"

module acr_sar #(
  parameter RES_BITS = `ACR_RES_BITS
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // control
  input wire start,
  input wire abort,
  input wire tad_tick,
  input wire comp_in,
  // results
  output reg busy,
  output reg finish,
  output reg [RES_BITS-1:0] trial,
  output reg [RES_BITS-1:0] result
);

  reg [RES_BITS-1:0] bit_mask;
  reg sampling;
  integer i;
  reg [RES_BITS-1:0] fill;

  // fill unconverted bits with last decided bit
  // the bit under test is still tentative, so it is filled as well
  always @* begin
    fill = trial;
    for (i = RES_BITS - 2; i >= 0; i = i - 1) begin
      if ((bit_mask >> i) != {RES_BITS{1'b0}}) begin
        fill[i] = fill[i+1];
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      finish <= 1'b0;
      sampling <= 1'b0;
      bit_mask <= {RES_BITS{1'b0}};
      trial <= {RES_BITS{1'b0}};
      result <= {RES_BITS{1'b0}};
    end else begin
      finish <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        sampling <= 1'b1;
        bit_mask <= {1'b1, {(RES_BITS-1){1'b0}}};
        trial <= {1'b1, {(RES_BITS-1){1'b0}}};
      end else if (busy && abort) begin
        busy <= 1'b0;
        finish <= 1'b1;
        result <= fill;
      end else if (busy && tad_tick) begin
        if (sampling) begin
          sampling <= 1'b0;
        end else begin
          if (!comp_in) begin
            trial <= (trial & ~bit_mask) | (bit_mask >> 1);
          end else begin
            trial <= trial | (bit_mask >> 1);
          end
          bit_mask <= bit_mask >> 1;
          if (bit_mask[0]) begin
            busy <= 1'b0;
            finish <= 1'b1;
            result <= comp_in ? trial : (trial & ~bit_mask);
          end
        end
      end
    end
  end

endmodule // acr_sar
`default_nettype wire

// ===== verilog/acr_top.v
// converter control register bank with apb slave
`timescale 1ns/100ps
`default_nettype none
`include "acr_regs.vh"

module acr_top (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // converter core
  input wire comp_in,
  input wire rc_tick,
  input wire special_trigger,
  output reg [4:0] input_route,
  output reg route_valid,
  output reg route_dac,
  output reg route_refbuf,
  output reg [9:0] dac_trial,
  output reg core_power,
  output reg negative_reference_select,
  output reg [1:0] positive_reference_select,
  output reg conversion_done_flag
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [4:0] input_selector;
  reg go_flag;
  reg converter_enable;
  reg justification_select;
  reg [2:0] conversion_clock_select;
  reg neg_ref;
  reg [1:0] pos_ref;
  reg [7:0] conversion_result_high;
  reg [7:0] conversion_result_low;
  reg done_sticky;

  wire apb_write;
  wire apb_read;
  wire tad_tick;
  wire sar_busy;
  wire sar_finish;
  wire [9:0] sar_trial;
  wire [9:0] sar_result;
  wire go_written_one;
  wire go_written_zero;
  wire [7:0] ctrl0_read;
  wire [7:0] ctrl1_read;
  reg [31:0] next_prdata;
  reg next_slverr;

  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && !penable && !pwrite;
  assign go_written_one = apb_write && paddr == `ACR_OFF_CTRL0 && pwdata[`ACR_C0_GO];
  assign go_written_zero = apb_write && paddr == `ACR_OFF_CTRL0 && !pwdata[`ACR_C0_GO];

  assign ctrl0_read = {1'b0, input_selector, go_flag, converter_enable};
  assign ctrl1_read = {justification_select, conversion_clock_select, 1'b0, neg_ref, pos_ref};

  // ----------------------------------------
  // sub blocks
  // ----------------------------------------
  acr_clkdiv u_div (
    .clk(clk),
    .rst_b(rst_b),
    .run(sar_busy),
    .clock_select(conversion_clock_select),
    .rc_tick(rc_tick),
    .tad_tick(tad_tick)
  );

  // a start on a disabled converter is held until enable, but a ctrl0 write with go zero clears it first
  acr_sar #(.RES_BITS(`ACR_RES_BITS)) u_sar (
    .clk(clk),
    .rst_b(rst_b),
    // go clears one cycle after finish; block a restart in that cycle
    .start(go_flag && converter_enable && !sar_finish),
    .abort(!go_flag || !converter_enable),
    .tad_tick(tad_tick),
    .comp_in(comp_in),
    .busy(sar_busy),
    .finish(sar_finish),
    .trial(sar_trial),
    .result(sar_result)
  );

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      input_selector <= 5'h00;
      go_flag <= 1'b0;
      converter_enable <= 1'b0;
      justification_select <= 1'b0;
      conversion_clock_select <= 3'h0;
      neg_ref <= 1'b0;
      pos_ref <= 2'h0;
    end else begin
      if (apb_write && paddr == `ACR_OFF_CTRL0) begin
        input_selector <= pwdata[`ACR_C0_SEL_HI:`ACR_C0_SEL_LO];
        converter_enable <= pwdata[`ACR_C0_EN];
      end
      if (apb_write && paddr == `ACR_OFF_CTRL1) begin
        justification_select <= pwdata[`ACR_C1_JUST];
        conversion_clock_select <= pwdata[`ACR_C1_CLK_HI:`ACR_C1_CLK_LO];
        neg_ref <= pwdata[`ACR_C1_NREF];
        pos_ref <= pwdata[`ACR_C1_PREF_HI:`ACR_C1_PREF_LO];
      end
      if (go_written_one || special_trigger) begin
        go_flag <= 1'b1;
      end else if (go_written_zero) begin
        go_flag <= 1'b0;
      end else if (sar_finish) begin
        go_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      conversion_result_high <= 8'h00;
      conversion_result_low <= 8'h00;
      done_sticky <= 1'b0;
    end else begin
      if (sar_finish) begin
        if (justification_select) begin
          conversion_result_high <= {6'h00, sar_result[9:8]};
          conversion_result_low <= sar_result[7:0];
        end else begin
          conversion_result_high <= sar_result[9:2];
          conversion_result_low <= {sar_result[1:0], 6'h00};
        end
      end else begin
        if (apb_write && paddr == `ACR_OFF_RESH) begin
          conversion_result_high <= pwdata[7:0];
        end
        if (apb_write && paddr == `ACR_OFF_RESL) begin
          conversion_result_low <= pwdata[7:0];
        end
      end
      // done flag, set wins over clear
      if (sar_finish) begin
        done_sticky <= 1'b1;
      end else if (apb_write && paddr == `ACR_OFF_STAT && pwdata[`ACR_ST_DONE]) begin
        done_sticky <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // converter side outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      input_route <= `ACR_SEL_NONE;
      route_valid <= 1'b0;
      route_dac <= 1'b0;
      route_refbuf <= 1'b0;
      dac_trial <= 10'h000;
      core_power <= 1'b0;
      negative_reference_select <= 1'b0;
      positive_reference_select <= 2'h0;
      conversion_done_flag <= 1'b0;
    end else begin
      input_route <= input_selector;
      route_valid <= input_selector <= `ACR_SEL_LAST_AN;
      route_dac <= input_selector == `ACR_SEL_DAC;
      route_refbuf <= input_selector == `ACR_SEL_REFBUF;
      dac_trial <= sar_trial;
      core_power <= converter_enable;
      negative_reference_select <= neg_ref;
      // positive reference, reserved code passed as written
      positive_reference_select <= pos_ref;
      conversion_done_flag <= done_sticky || sar_finish;
    end
  end

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      `ACR_OFF_CTRL0: next_prdata = {24'h000000, ctrl0_read};
      `ACR_OFF_CTRL1: next_prdata = {24'h000000, ctrl1_read};
      `ACR_OFF_RESH: next_prdata = {24'h000000, conversion_result_high};
      `ACR_OFF_RESL: next_prdata = {24'h000000, conversion_result_low};
      `ACR_OFF_STAT: next_prdata = {31'h00000000, done_sticky};
      default: next_slverr = 1'b1;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_slverr;
      if (apb_read) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule // acr_top
`default_nettype wire

// ===== test/acr_core.sv
// behavioural model of the sampling comparator and rc oscillator
`timescale 1ns/100ps
`default_nettype none
module acr_core #(
  parameter int RC_DIV = 5
) (
  // clock
  input wire logic clk,
  // converter side
  input wire logic [9:0] dac_trial,
  input wire logic core_power,
  input wire logic [9:0] level,
  output logic comp_in,
  output logic rc_tick
);
  int rc_cnt = 0;
  logic tog = 1'b0;
  // unpowered comparator gives no steady answer, so toggle
  assign comp_in = core_power ? (level >= dac_trial) : tog;
  always @(posedge clk) begin
    tog <= ~tog;
    rc_cnt <= (rc_cnt >= RC_DIV - 1) ? 0 : rc_cnt + 1;
    rc_tick <= (rc_cnt == 0);
  end
endmodule // acr_core
`default_nettype wire

// ===== test/acr_chk.sv
// assertions on the converter control bank ports
`timescale 1ns/100ps
`default_nettype none
module acr_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic [4:0] input_route,
  input wire logic route_valid,
  input wire logic route_dac,
  input wire logic route_refbuf,
  input wire logic core_power,
  input wire logic negative_reference_select,
  input wire logic [1:0] positive_reference_select,
  input wire logic conversion_done_flag
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  a_route_an: assert property (
    route_valid == (input_route <= 5'h0b)) else $error("analog route flag wrong");
  a_route_dac: assert property (
    route_dac == (input_route == 5'h1e)) else $error("dac route flag wrong");
  a_route_buf: assert property (
    route_refbuf == (input_route == 5'h1f)) else $error("buffer route flag wrong");
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single access pulse");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_unmap: assert property (psel && !penable && paddr > 12'h010 |=> pslverr)
    else $error("unmapped access not refused");
  a_en_write: assert property (wr_acc && paddr == 12'h000 |=> ##1
    core_power == $past(pwdata[0], 2) && input_route == $past(pwdata[6:2], 2))
    else $error("enable or selector not taken");
  a_ref_write: assert property (wr_acc && paddr == 12'h004 |=> ##1
    negative_reference_select == $past(pwdata[2], 2)
    && positive_reference_select == $past(pwdata[1:0], 2))
    else $error("reference selects not taken");
  a_reset_idle: assert property ($rose(rst_b) |-> !core_power
    && !conversion_done_flag && input_route == 5'h1d && positive_reference_select == 2'h0)
    else $error("outputs not idle after reset");
endmodule // acr_chk
bind acr_top acr_chk u_acr_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .input_route(input_route), .route_valid(route_valid), .route_dac(route_dac),
  .route_refbuf(route_refbuf), .core_power(core_power),
  .negative_reference_select(negative_reference_select),
  .positive_reference_select(positive_reference_select),
  .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the converter control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic trig = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [9:0] level = 10'h000;
  logic [9:0] dac_trial;
  logic [4:0] input_route;
  logic [1:0] pref;
  logic [7:0] hi;
  logic pready, pslverr, comp_in, rc_tick, rv, rdac, rbuf, pwr, nref, done, err, j;
  int n_mismatch = 0;
  int checked = 0;
  int cyc;
  int t;
  acr_top u_acr_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_in(comp_in), .rc_tick(rc_tick), .special_trigger(trig),
    .input_route(input_route), .route_valid(rv), .route_dac(rdac), .route_refbuf(rbuf),
    .dac_trial(dac_trial), .core_power(pwr), .negative_reference_select(nref),
    .positive_reference_select(pref), .conversion_done_flag(done));
  acr_core #(.RC_DIV(5)) u_acr_core (.clk(clk), .dac_trial(dac_trial), .core_power(pwr),
    .level(level), .comp_in(comp_in), .rc_tick(rc_tick));
  initial forever #25 clk = ~clk;
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("bus answer", 32'h1, 32'(n < 20));
    if (n == 20) end_of_test();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done();
    cyc = 0;
    while (done !== 1'b1 && cyc < 3000) begin
      @(posedge clk);
      cyc++;
    end
    chk("done wait", 32'h1, 32'(cyc < 3000));
    if (cyc == 3000) end_of_test();
  endtask
  function automatic int tad(input logic [2:0] c);
    return (c[1:0] == 2'h3) ? 5 : 2 << (2 * c[1:0] + c[2]);
  endfunction
  // partial result: top n bits decided, the rest copy the last one
  function automatic logic part_ok(input logic [9:0] v, input logic [9:0] r);
    part_ok = 1'b0;
    for (int n = 1; n < 10; n++)
      if (r === ((v & ~(10'h3ff >> n)) | (v[10 - n] ? 10'h3ff >> n : 10'h000)))
        part_ok = 1'b1;
  endfunction
  task automatic convert(input logic [2:0] c, input logic [9:0] v);
    j = 1'($urandom);
    level <= v;
    t = tad(c);
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b1, 12'h004, {24'h0, j, c, 4'h0});
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    chk("go while busy", 32'h3, rd);
    wait_done();
    chk("conv time", 32'h1, 32'(cyc >= 11 * t - 4 && cyc <= 12 * t + 8));
    apb(1'b0, 12'h000, 32'h0);
    chk("go after done", 32'h1, rd);
    apb(1'b0, 12'h008, 32'h0);
    hi = rd[7:0];
    apb(1'b0, 12'h00c, 32'h0);
    chk("result", 32'(j ? {6'h0, v} : {v, 6'h0}), {16'h0, hi, rd[7:0]});
    apb(1'b0, 12'h010, 32'h0);
    chk("done flag", 32'h1, rd);
  endtask
  initial begin
    void'($urandom(9));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 3; a++) begin
      apb(1'b0, 12'(4 * a * a), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b1, 12'h014, 32'hff);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, 32'(err));
    $display("test reset and map done");
    apb(1'b1, 12'h000, 32'hffff_fffd);
    apb(1'b0, 12'h000, 32'h0);
    chk("primary bits", 32'h7d, rd);
    chk("power on", 32'h1, 32'(pwr));
    apb(1'b1, 12'h004, 32'hffff_ffff);
    apb(1'b0, 12'h004, 32'h0);
    chk("secondary bits", 32'hf7, rd);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 12'h004, 32'(p + 4 * (p % 2)));
      repeat (2) @(posedge clk);
      chk("negative ref", 32'(p % 2), 32'(nref));
      chk("positive ref", 32'(p), 32'(pref));
    end
    for (int s = 0; s < 32; s++) begin
      apb(1'b1, 12'h000, 32'(4 * s));
      repeat (2) @(posedge clk);
      chk("route", 32'({5'(s), s <= 11, s == 30, s == 31}), 32'({input_route, rv, rdac, rbuf}));
    end
    $display("test control fields done");
    for (int c = 0; c < 8; c++)
      convert(3'(c), c == 0 ? 10'h3ff : c == 1 ? 10'h000 : 10'($urandom));
    $display("test conversions done");
    level <= 10'h2a5;
    apb(1'b1, 12'h004, 32'h60);
    apb(1'b1, 12'h000, 32'h3);
    repeat (350) @(posedge clk);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("go after abort", 32'h1, rd);
    apb(1'b0, 12'h008, 32'h0);
    hi = rd[7:0];
    apb(1'b0, 12'h00c, 32'h0);
    chk("partial result", 32'h1, 32'(part_ok(10'h2a5, {hi, rd[7:6]})));
    $display("test abort done");
    apb(1'b1, 12'h010, 32'h1);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("triggered go", 32'h3, rd);
    wait_done();
    chk("trigger done", 32'h1, 32'(done));
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge clk);
    chk("power off", 32'h0, 32'(pwr));
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("done cleared", 32'h0, rd);
    $display("test trigger and disable done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
